// ---- pkg/adcsr_pkg.sv ----
// constants for the core status and soft reset register pair
// assumes one 50 MHz configuration clock shared by all users of this package
package adcsr_pkg;
	// register access port geometry
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 16;
	localparam int          CORE_N         = 4;
	// register offsets
	localparam logic [7:0]  STATUS_ADDR    = 8'h02;
	localparam logic [7:0]  SWRST_ADDR     = 8'h04;
	// field positions and values after reset
	localparam int          SWRST_BIT      = 0;
	localparam logic [3:0]  STATUS_RST     = 4'hf;
	localparam logic        SWRST_RST      = 1'b0;
	// soft reset pulse: a few ns, held as a longest time so it rounds down
	localparam int          CLK_PERIOD_NS  = 20;
	localparam int          SOFT_RST_NS    = 40;
	localparam int          SOFT_RST_CYC_I = (SOFT_RST_NS / CLK_PERIOD_NS) < 1 ? 1 : (SOFT_RST_NS / CLK_PERIOD_NS);
	localparam logic [2:0]  SOFT_RST_CYC   = 3'(SOFT_RST_CYC_I);
	localparam logic [2:0]  CNT_RST        = 3'h0;
	// pulse generator states
	typedef enum logic [0:0] {ADCSR_IDLE, ADCSR_PULSE} adcsr_state_t;
endpackage

// ---- verilog/adcsr_pulse.sv ----
// soft reset pulse generator: holds the reset bit for a fixed count, then clears it
// assumes only the external reset clears it, so the pulse it makes cannot cut itself short
`timescale 1ns/100ps
`default_nettype none
module adcsr_pulse
	import adcsr_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// trigger and pulse
	input  wire logic trigger,
	output logic      pulse_r
);
	adcsr_state_t state_r;
	adcsr_state_t state_nxt;
	logic [2:0]   cnt_r;
	logic [2:0]   cnt_nxt;
	logic         pulse_nxt;

	// next state: count the pulse length and drop the bit by itself
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		pulse_nxt = pulse_r;
		case (state_r)
			ADCSR_IDLE: begin
				if (trigger) begin
					state_nxt = ADCSR_PULSE;
					cnt_nxt   = 3'h1;
					pulse_nxt = 1'b1;
				end
			end
			ADCSR_PULSE: begin
				if (cnt_r >= SOFT_RST_CYC) begin
					state_nxt = ADCSR_IDLE;
					cnt_nxt   = CNT_RST;
					pulse_nxt = SWRST_RST;
				end else begin
					cnt_nxt = cnt_r + 3'h1;
				end
			end
			default: begin
				state_nxt = ADCSR_IDLE;
				cnt_nxt   = CNT_RST;
				pulse_nxt = SWRST_RST;
			end
		endcase
	end

	// registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= ADCSR_IDLE;
			cnt_r   <= CNT_RST;
			pulse_r <= SWRST_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// the bit never stands longer than four cycles after it rises
	pulse_len_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(pulse_r) |-> ##[1:4] !pulse_r)
		else $error("soft reset bit did not clear by itself");
endmodule
`default_nettype wire

// ---- verilog/adcsr_regs.sv ----
// core status word and self-clearing soft reset register behind the serial port decoder
// assumes the decoder hands over one-cycle read and write strobes on ref_clk
// and that core activity levels come from the analog side, asynchronous to ref_clk
// and that the rest of the digital logic treats soft_reset_out as a synchronous reset
// and that no host relies on an access landing while that reset stands
`timescale 1ns/100ps
`default_nettype none
module adcsr_regs
	import adcsr_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset,
	// register access from the serial port decoder
	input  wire logic [ADDR_W-1:0] cfg_addr,
	input  wire logic              cfg_wr_en,
	input  wire logic              cfg_rd_en,
	input  wire logic [DATA_W-1:0] cfg_wdata,
	output logic      [DATA_W-1:0] cfg_rdata_r,
	output logic                   cfg_rd_valid_r,
	// core activity from the converter cores
	input  wire logic [CORE_N-1:0] core_active_in,
	// soft reset to the rest of the digital logic
	output logic                   soft_reset_out
);
	logic [CORE_N-1:0] core_sync1_r;
	logic [CORE_N-1:0] core_active_flags_r;
	logic [CORE_N-1:0] core_sync1_nxt;
	logic [CORE_N-1:0] core_active_flags_nxt;
	logic [DATA_W-1:0] rdata_nxt;
	logic              rd_valid_nxt;
	logic              global_soft_reset_bit;
	logic              swrst_trigger;
	logic              rst_int;

	// soft reset fires only on a write of 1 to bit 0 of its word
	assign swrst_trigger = cfg_wr_en && (cfg_addr == SWRST_ADDR) && cfg_wdata[SWRST_BIT];

	// everything except the pulse generator falls under the soft reset too
	// a plain or keeps the reload on the very edges the bit stands, at the cost of a logic-fed reset
	assign rst_int = reset | global_soft_reset_bit;

	// soft reset timing: the write is taken at edge t, the bit reads high at t+1 and t+2,
	// and every register below is reloaded on those two edges; the bit is low again at t+3.
	// reads or writes that land on t+1 or t+2 are lost, a limitation hosts must allow for.
	// the pulse generator stays on the external reset only, so the pulse runs its full length
	adcsr_pulse u_pulse (
		.ref_clk (ref_clk),
		.reset   (reset),
		.trigger (swrst_trigger),
		.pulse_r (global_soft_reset_bit)
	);

	assign soft_reset_out = global_soft_reset_bit;

	// no pulse ever starts without a write of 1 to the reset bit
	swrst_cause_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(soft_reset_out) |-> $past(swrst_trigger))
		else $error("soft reset started without a trigger");

	// writes anywhere but the reset word never start a pulse
	swrst_other_a: assert property (@(posedge ref_clk) disable iff (reset)
		cfg_wr_en && cfg_addr != SWRST_ADDR && !soft_reset_out |=> !soft_reset_out)
		else $error("write to another word started a soft reset");

	// a second trigger inside the pulse does not stretch it
	swrst_retrig_a: assert property (@(posedge ref_clk) disable iff (reset)
		soft_reset_out && $past(soft_reset_out) |=> !soft_reset_out)
		else $error("soft reset pulse stretched past two cycles");

	// the external reset leaves the reset bit at its default of zero
	swrst_default_a: assert property (@(posedge ref_clk)
		reset |=> !soft_reset_out)
		else $error("soft reset bit not cleared by reset");

	// core activity crosses from the analog side through two flops
	always_comb begin
		core_sync1_nxt        = core_active_in;
		core_active_flags_nxt = core_sync1_r;
	end

	// synchroniser flops; either reset reloads the all-active default into both stages
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			core_sync1_r        <= STATUS_RST;
			core_active_flags_r <= STATUS_RST;
		end else begin
			core_sync1_r        <= core_sync1_nxt;
			core_active_flags_r <= core_active_flags_nxt;
		end
	end

	// the first stage only samples the pins; nothing else may read it
	sync_follow_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		!rst_int |=> core_sync1_r == $past(core_active_in))
		else $error("first synchroniser stage missed the core levels");

	// both stages reload the all-active default under either reset
	sync_reset_a: assert property (@(posedge ref_clk)
		rst_int |=> core_sync1_r == STATUS_RST && core_active_flags_r == STATUS_RST)
		else $error("synchroniser not reloaded by reset");

	// a host write to the status word must not reach the flags
	status_write_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		cfg_wr_en && cfg_addr == STATUS_ADDR |=> core_active_flags_r == $past(core_sync1_r))
		else $error("status write disturbed the core flags");

	// the soft reset leaves the flags showing all cores active as it ends
	flags_soft_a: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(soft_reset_out) |-> core_active_flags_r == STATUS_RST && core_sync1_r == STATUS_RST)
		else $error("flags not at default when the soft reset ends");

	// per core: each flag tracks its own core two edges late, bit 0 for core A
	for (genvar i = 0; i < CORE_N; i++) begin : g_core_chk
		core_flag_a: assert property (@(posedge ref_clk) disable iff (rst_int)
			!$past(rst_int, 1) && !$past(rst_int, 2) |-> core_active_flags_r[i] == $past(core_active_in[i], 2))
			else $error("core flag does not track its own core");
	end

	// read mux: one cycle of latency, unmapped and unused bits read zero;
	// the answer is held for one cycle only, so the decoder must take it at once
	always_comb begin
		rdata_nxt    = '0;
		rd_valid_nxt = cfg_rd_en;
		if (cfg_rd_en) begin
			case (cfg_addr)
				STATUS_ADDR: rdata_nxt[CORE_N-1:0] = core_active_flags_r;
				SWRST_ADDR:  rdata_nxt[SWRST_BIT]  = global_soft_reset_bit;
				default:     rdata_nxt             = '0;
			endcase
		end
	end

	// answer registers; clearing them under soft reset drops any read in flight
	always_ff @(posedge ref_clk) begin
		if (rst_int) begin
			cfg_rdata_r    <= '0;
			cfg_rd_valid_r <= 1'b0;
		end else begin
			cfg_rdata_r    <= rdata_nxt;
			cfg_rd_valid_r <= rd_valid_nxt;
		end
	end

	// every read taken outside a reset is answered on the next edge
	rd_answer_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		cfg_rd_en |=> cfg_rd_valid_r)
		else $error("read not answered one cycle later");

	// with no read taken the answer lines fall back to zero
	rd_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		!cfg_rd_en |=> !cfg_rd_valid_r && cfg_rdata_r == 16'h0000)
		else $error("read answer stood without a read");

	// reads of words that do not exist return zero
	rd_unmapped_a: assert property (@(posedge ref_clk) disable iff (reset)
		cfg_rd_en && cfg_addr != STATUS_ADDR && cfg_addr != SWRST_ADDR |=> cfg_rdata_r == 16'h0000)
		else $error("unmapped read returned nonzero data");

	// either reset drops a read in flight
	rd_lost_a: assert property (@(posedge ref_clk)
		rst_int |=> !cfg_rd_valid_r && cfg_rdata_r == 16'h0000)
		else $error("read answered during a reset");

	// a read of the reset word during its own pulse is lost rather than showing the bit
	swrst_rd_lost_a: assert property (@(posedge ref_clk)
		soft_reset_out && cfg_rd_en |=> !cfg_rd_valid_r)
		else $error("read of the reset word answered inside the pulse");

	// writes are never answered on the read lines
	wr_silent_a: assert property (@(posedge ref_clk) disable iff (reset)
		cfg_wr_en && !cfg_rd_en |=> !cfg_rd_valid_r)
		else $error("write produced a read answer");

	// status read returns the synchronised core flags, upper bits zero
	status_read_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		cfg_rd_en && cfg_addr == STATUS_ADDR && !swrst_trigger
		|=> cfg_rdata_r == {12'h000, $past(core_active_flags_r)})
		else $error("status read data wrong");

	status_default_a: assert property (@(posedge ref_clk)
		reset |=> core_active_flags_r == 4'hf)
		else $error("status flags not all ones after reset");

	// flags follow the core inputs only, two edges late, whatever the host writes
	status_ro_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		!$past(rst_int, 1) && !$past(rst_int, 2) |-> core_active_flags_r == $past(core_active_in, 2))
		else $error("status flags disturbed by something other than the cores");

	swrst_fire_a: assert property (@(posedge ref_clk) disable iff (reset)
		swrst_trigger && !soft_reset_out |=> soft_reset_out [*2])
		else $error("write of 1 did not raise a two-cycle soft reset");

	swrst_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
		cfg_wr_en && cfg_addr == SWRST_ADDR && !cfg_wdata[0] && !soft_reset_out |=> !soft_reset_out)
		else $error("write of 0 caused a soft reset");

	reset_all_a: assert property (@(posedge ref_clk) disable iff (reset)
		soft_reset_out |=> !cfg_rd_valid_r && cfg_rdata_r == 16'h0000 && core_active_flags_r == 4'hf)
		else $error("soft reset left state unreset");

	swrst_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(soft_reset_out) |-> soft_reset_out ##1 soft_reset_out ##1 !soft_reset_out)
		else $error("soft reset bit did not clear after two cycles");

	swrst_read_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		cfg_rd_en && cfg_addr == SWRST_ADDR && !swrst_trigger |=> cfg_rdata_r == 16'h0000)
		else $error("soft reset word read nonzero while idle");

	unused_zero_a: assert property (@(posedge ref_clk) disable iff (rst_int)
		cfg_rd_en |=> cfg_rdata_r[15:4] == 12'h000)
		else $error("unused bits read nonzero");
endmodule
`default_nettype wire

// ---- tb/adcsr_host.sv ----
// host model: serial port decoder side driving the register strobes
// assumes the device samples one strobe per access on the rising edge of ref_clk
`timescale 1ns/100ps
`default_nettype none
module adcsr_host
	import adcsr_pkg::*;
(
	// clock
	input  wire logic              ref_clk,
	// register strobes
	output var  logic [ADDR_W-1:0] cfg_addr,
	output var  logic              cfg_wr_en,
	output var  logic              cfg_rd_en,
	output var  logic [DATA_W-1:0] cfg_wdata
);
	// bus starts idle
	initial begin
		cfg_addr = 8'h00;
		cfg_wr_en = 1'b0;
		cfg_rd_en = 1'b0;
		cfg_wdata = 16'h0000;
	end
	// one-cycle access; address and data inverted after, so stale values never pass for live ones
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		cfg_wr_en <= w;
		cfg_rd_en <= !w;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr_en <= 1'b0;
		cfg_rd_en <= 1'b0;
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// testbench for the core status and soft reset register pair
// assumes the host model owns the strobes and the bench owns reset and core levels
`timescale 1ns/100ps
`default_nettype none
module tb;
	import adcsr_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] core = 4'h0; // differs from the reset default, so the default is really seen
	logic [7:0] addr;
	logic wr, rd_s, rvalid, srst;
	logic [15:0] wdata, rdata;
	integer seed = 26;
	integer num_errors = 0;
	integer num_checks = 0;
	integer cyc = 0;
	always #10 ref_clk = ~ref_clk;
	adcsr_host host (.ref_clk(ref_clk), .cfg_addr(addr), .cfg_wr_en(wr), .cfg_rd_en(rd_s), .cfg_wdata(wdata));
	adcsr_regs dut (.ref_clk(ref_clk), .reset(reset), .cfg_addr(addr), .cfg_wr_en(wr), .cfg_rd_en(rd_s),
		.cfg_wdata(wdata), .cfg_rdata_r(rdata), .cfg_rd_valid_r(rvalid), .core_active_in(core),
		.soft_reset_out(srst));
	// compare one value, case equality so unknowns fail
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// status word expected from the core levels
	function automatic logic [15:0] stat_exp(input logic [3:0] c);
		return {12'h000, c};
	endfunction
	// read, then look at the answer in the one cycle it stands
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		host.acc(1'b0, a, 16'h0000);
		#1;
		chk({15'h0000, rvalid}, 16'h0001);
		chk(rdata, e);
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard: whole run needs well under 300 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd(STATUS_ADDR, 16'h000f);
		rd(SWRST_ADDR, 16'h0000);
		rd(8'h33, 16'h0000);
		// random core levels, each with a write attempt to the read-only word
		for (int i = 0; i < 12; i++) begin
			@(posedge ref_clk);
			core <= 4'($random(seed));
			repeat (3) @(posedge ref_clk);
			host.acc(1'b1, STATUS_ADDR, 16'($random(seed)));
			rd(STATUS_ADDR, stat_exp(core));
		end
		// bit 0 clear: no reset even with all the upper bits set
		host.acc(1'b1, SWRST_ADDR, 16'hfffe);
		repeat (2) begin
			#1;
			chk({15'h0000, srst}, 16'h0000);
			@(posedge ref_clk);
		end
		core <= 4'h0;
		host.acc(1'b1, SWRST_ADDR, 16'h0001);
		#1;
		chk({15'h0000, srst}, 16'h0001);
		// a read taken inside the pulse is dropped, then the bit has cleared itself
		host.acc(1'b0, SWRST_ADDR, 16'h0000);
		#1;
		chk({srst, 14'h0000, rvalid}, 16'h0000);
		// first read after the pulse still shows the reloaded default, cores being idle
		rd(STATUS_ADDR, {12'h000, STATUS_RST});
		repeat (3) @(posedge ref_clk);
		rd(STATUS_ADDR, stat_exp(4'h0));
		rd(SWRST_ADDR, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
